//--- include/wbp_pkg.sv
// Constants for the word/byte parallel data port of the converter.
// Assumes a single 50 MHz ref_clk domain; all port pins arrive asynchronously.
package wbp_pkg;
    localparam int WORD_W = 12;               // Full transfer width
    localparam int BYTE_W = 8;                // Byte mode transfer width
    localparam int CHAN_W = 2;                // Channel identifier width
    localparam int NIB_W = 4;                 // Upper bits carried in the high byte
    localparam int SHARED_POS = 8;            // Index of the shared bit8/select pin
    localparam int CHAN_POS = 4;              // Channel id position in the high byte
    localparam int ZERO_POS = 6;              // Forced-zero field in the high byte
    localparam int ZERO_W = 2;                // Width of the forced-zero field
    localparam int SYNC_STAGES = 3;           // Flops on every pin input
    localparam int PIN_W = WORD_W + 4;        // Synchronised pin bundle width
    localparam logic [WORD_W-1:0] CTRL_RST = 12'h000; // Control word after reset
    localparam logic [BYTE_W-1:0] LOW_RST = 8'h00;    // Held low byte after reset
    // Idle pin levels: strobes and select high, word select low, data low
    localparam logic [PIN_W-1:0] PIN_RST = 16'h7000;
endpackage

//--- rtl/wbp_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs may change at any time relative to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module wbp_sync #(
    parameter int W = 1,                      // Number of pins
    parameter logic [W-1:0] RST_VAL = '0      // Level assumed during reset
) (
    input wire logic ref_clk,                 // System clock
    input wire logic rst_b,                   // Async reset, active low
    input wire logic [W-1:0] pin_in,          // Raw asynchronous pins
    output logic [W-1:0] level_q              // Filtered, synchronous level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    if (W < 1) begin : g_bad_width
        $error("wbp_sync: W must be at least 1");
    end

    // Shift chain; only s2 reads s1 so metastability stays contained
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= RST_VAL;
        end else begin
            level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
        end
    end
endmodule
`default_nettype wire

//--- rtl/wbp_port.sv
// Word/byte parallel data port: returns results and accepts control writes.
// Assumes the converter core presents result data and channel on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module wbp_port (
    input wire logic ref_clk,                              // 50 MHz clock
    input wire logic rst_b,                                // Async reset, active low
    input wire logic word_sel,                             // Pin: high word, low byte
    input wire logic cs_b,                                 // Pin: chip select, low
    input wire logic rd_b,                                 // Pin: read strobe, low
    input wire logic wr_b,                                 // Pin: write strobe, low
    input wire logic [wbp_pkg::WORD_W-1:0] data_in,        // Pins in; bit 8 shared
    output logic [wbp_pkg::WORD_W-1:0] data_out,           // Pins out
    output logic [wbp_pkg::WORD_W-1:0] data_oe,            // Pin drive, high drives
    input wire logic [wbp_pkg::WORD_W-1:0] result_data,    // Core: latest result
    input wire logic [wbp_pkg::CHAN_W-1:0] result_chan,    // Core: result channel
    output logic result_taken,                             // Pulse: read began
    output logic [wbp_pkg::WORD_W-1:0] ctrl_word,          // Control register value
    output logic ctrl_load                                 // Pulse: control updated
);
    import wbp_pkg::*;

    logic [PIN_W-1:0] pins_f;
    logic word_f;
    logic cs_f;
    logic rd_f;
    logic wr_f;
    logic [WORD_W-1:0] din_f;
    logic hbs_f;
    logic rd_prev_q;
    logic wr_prev_q;
    logic rd_start;
    logic rd_end;
    logic wr_end;
    logic [WORD_W-1:0] data_out_q;
    logic [WORD_W-1:0] data_oe_q;
    logic [WORD_W-1:0] ctrl_q;
    logic [BYTE_W-1:0] low_q;
    logic ctrl_load_q;
    logic taken_q;

    // The byte image and the pin bundle rely on the fields tiling the
    // byte and the word exactly; refuse a package that breaks that.
    if (NIB_W + BYTE_W != WORD_W || CHAN_POS < NIB_W ||
        CHAN_POS + CHAN_W > ZERO_POS || ZERO_POS + ZERO_W != BYTE_W ||
        PIN_W != WORD_W + 4 || SYNC_STAGES != 3) begin : g_bad_layout
        $error("wbp_port: package field layout is inconsistent");
    end

    // All pins arrive from outside the clock domain
    wbp_sync #(
        .W(PIN_W),
        .RST_VAL(PIN_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in({word_sel, cs_b, rd_b, wr_b, data_in}),
        .level_q(pins_f)
    );

    assign word_f = pins_f[PIN_W-1];
    assign cs_f = pins_f[PIN_W-2];
    assign rd_f = pins_f[PIN_W-3];
    assign wr_f = pins_f[PIN_W-4];
    assign din_f = pins_f[WORD_W-1:0];
    assign hbs_f = din_f[SHARED_POS] & ~word_f;    // Select only exists in byte mode

    // Strobe edge history
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_prev_q <= 1'b1;
            wr_prev_q <= 1'b1;
        end else begin
            rd_prev_q <= rd_f;
            wr_prev_q <= wr_f;
        end
    end

    // Reads need chip select; a read overlapping a write is ignored.
    // A strobe that falls before chip select does not start a read, so
    // hosts must select first; this keeps a glitching select harmless.
    assign rd_start = rd_prev_q & ~rd_f & ~cs_f & wr_f;
    assign rd_end = rd_f | cs_f;
    assign wr_end = ~wr_prev_q & wr_f & ~cs_f;

    // Returns the byte-mode image of a result for the selected half
    function automatic logic [BYTE_W-1:0] byte_image(
        input logic [WORD_W-1:0] res,
        input logic [CHAN_W-1:0] chan,
        input logic high
    );
        logic [BYTE_W-1:0] b;
        b = res[BYTE_W-1:0];
        if (high) begin
            b = '0;
            b[NIB_W-1:0] = res[WORD_W-1:BYTE_W];
            b[CHAN_POS +: CHAN_W] = chan;
        end
        return b;
    endfunction

    // Result capture at the read fall; held stable for the whole strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out_q <= '0;
        end else if (rd_start) begin
            if (word_f) begin
                data_out_q <= result_data;
            end else begin
                data_out_q <= {{(WORD_W-BYTE_W){1'b0}},
                               byte_image(result_data, result_chan, hbs_f)};
            end
        end
    end

    // Drive enables: byte mode leaves lines 8 to 11 undriven, so the
    // shared pin stays free to carry the high byte select
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_oe_q <= '0;
        end else if (rd_end) begin
            data_oe_q <= '0;
        end else if (rd_start) begin
            if (word_f) begin
                data_oe_q <= {WORD_W{1'b1}};
            end else begin
                data_oe_q <= {{(WORD_W-BYTE_W){1'b0}}, {BYTE_W{1'b1}}};
            end
        end
    end

    // Read notification to the core
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            taken_q <= 1'b0;
        end else begin
            taken_q <= rd_start;
        end
    end

    // Control writes land at the write strobe's rising edge. In byte mode
    // the low byte is held until the high byte completes the word, so the
    // core never sees a half-written control value. Lines 4 to 7 of a high
    // byte are expected to be zero and are not used.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            low_q <= LOW_RST;
            ctrl_load_q <= 1'b0;
        end else begin
            ctrl_load_q <= 1'b0;
            if (wr_end) begin
                if (word_f) begin
                    ctrl_q <= din_f;
                    ctrl_load_q <= 1'b1;
                end else if (!hbs_f) begin
                    low_q <= din_f[BYTE_W-1:0];
                end else begin
                    ctrl_q <= {din_f[NIB_W-1:0], low_q};
                    ctrl_load_q <= 1'b1;
                end
            end
        end
    end

    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign result_taken = taken_q;
    assign ctrl_word = ctrl_q;
    assign ctrl_load = ctrl_load_q;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_word_drive: assert property (rd_start && word_f |=> data_oe_q == 12'hFFF &&
        data_out_q == $past(result_data)) else $error("word read not driven");
    a_byte_lines: assert property (rd_start && !word_f |=> data_oe_q == 12'h0FF)
        else $error("byte read drives wrong lines");
    a_shared_free: assert property (!word_f && rd_start |=> !data_oe_q[8])
        else $error("shared pin driven in byte mode");
    a_low_byte: assert property (rd_start && !word_f && !hbs_f |=>
        data_out_q[7:0] == $past(result_data[7:0])) else $error("low byte wrong");
    a_high_nibble: assert property (rd_start && !word_f && hbs_f |=>
        data_out_q[3:0] == $past(result_data[11:8])) else $error("high nibble wrong");
    a_chan_id: assert property (rd_start && !word_f && hbs_f |=>
        data_out_q[5:4] == $past(result_chan)) else $error("channel id wrong");
    a_high_zero: assert property (rd_start && !word_f && hbs_f |=>
        data_out_q[7:6] == 2'h0) else $error("high byte top bits not zero");
    a_release: assert property (rd_f || cs_f |=> data_oe_q == 12'h000)
        else $error("bus not released");
    a_no_cs_read: assert property (cs_f && $fell(rd_f) |=> !taken_q)
        else $error("read taken without select");
    a_hold_drive: assert property (rd_start ##1 (!rd_f && !cs_f) [*2] |->
        $stable(data_out_q)) else $error("read data changed mid strobe");
    a_high_write: assert property (wr_end && !word_f && hbs_f |=> ctrl_load_q &&
        ctrl_q == {$past(din_f[3:0]), $past(low_q)}) else $error("high byte write wrong");
    a_low_write: assert property (wr_end && !word_f && !hbs_f |=> !ctrl_load_q &&
        low_q == $past(din_f[7:0])) else $error("low byte write wrong");

    // Pulses, refusals and the drive pattern; a stray control load or a
    // half-driven bus would corrupt the host side silently
    a_word_write: assert property (wr_end && word_f |=> ctrl_load_q &&
        ctrl_q == $past(din_f)) else $error("word write wrong");
    a_byte_upper: assert property (rd_start && !word_f |=> data_out_q[11:8] == 4'h0)
        else $error("byte read upper lines not clear");
    a_taken_pulse: assert property (rd_start |=> taken_q ##1 !taken_q)
        else $error("read pulse wrong");
    a_busy_write: assert property (!wr_f |=> !taken_q)
        else $error("read taken during write");
    a_cs_write: assert property (cs_f |=> !ctrl_load_q)
        else $error("write taken without select");
    a_ctrl_steady: assert property (!wr_end |=> !ctrl_load_q && $stable(ctrl_q))
        else $error("control word changed without write");
    a_drive_shape: assert property (data_oe_q == 12'h000 || data_oe_q == 12'h0FF ||
        data_oe_q == 12'hFFF) else $error("illegal drive pattern");

    c_word_read: cover property (rd_start && word_f);
    c_refused_read: cover property (cs_f && $fell(rd_f));
    c_high_read: cover property (rd_start && !word_f && hbs_f);
    c_word_write: cover property (wr_end && word_f);
    c_byte_pair: cover property (wr_end && !hbs_f && !word_f ##[1:50] wr_end && hbs_f);
endmodule
`default_nettype wire

//--- dv/wbp_host_model.sv
// Host bus model: a processor bus master driving the port pins.
// Assumes the bench calls its tasks just after a rising ref_clk edge.
`timescale 1ns/1ps
`default_nettype none
module wbp_host_model (
    input wire logic ref_clk,          // Port clock
    output logic word_sel,             // Word/byte select pin
    output logic cs_b,                 // Chip select, low
    output logic rd_b,                 // Read strobe, low
    output logic wr_b,                 // Write strobe, low
    output logic [11:0] data_in,       // Resolved data lines
    input wire logic [11:0] data_out,  // Device drive value
    input wire logic [11:0] data_oe,   // Device drive enable
    input wire logic result_taken,     // Read start pulse
    input wire logic ctrl_load         // Control update pulse
);
    logic [11:0] h_val;
    logic [11:0] h_drv;
    logic [11:0] flt_q;
    // Idle bus: strobes and select released
    initial begin
        word_sel = 1'b1; cs_b = 1'b1; rd_b = 1'b1; wr_b = 1'b1;
        h_val = 12'h000; h_drv = 12'h000; flt_q = 12'hA5A;
    end
    // Floating lines flip every cycle so a stale value can never look right
    always @(posedge ref_clk) flt_q <= ~flt_q;
    assign data_in = (data_oe & data_out) | (~data_oe & h_drv & h_val)
        | (~data_oe & ~h_drv & flt_q);
    // Read cycle; in byte mode the host owns the shared pin as select
    task automatic bus_read(input logic ws, input logic hb, input logic cs,
        output logic [11:0] d, output logic [11:0] oe, output logic tk);
        tk = 1'b0;
        word_sel = ws;
        // Byte mode: lines 9 to 11 are tied low on the board
        h_drv = ws ? 12'h000 : 12'hF00;
        h_val = {3'h0, hb, 8'h00};
        cs_b = cs; rd_b = 1'b0;
        for (int i = 0; i < 10 && !tk; i++) begin
            @(posedge ref_clk); #1;
            tk = result_taken;
        end
        d = data_out;
        oe = data_oe;
        cs_b = 1'b1; rd_b = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    // Write cycle; data held until the update pulse, past the strobe's end
    task automatic bus_write(input logic ws, input logic hb, input logic cs,
        input logic [11:0] d, output logic ld);
        ld = 1'b0;
        word_sel = ws;
        h_drv = ws ? 12'hFFF : 12'hFFF;
        h_val = ws ? d : {3'h0, hb, d[7:0]};
        cs_b = cs; wr_b = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        wr_b = 1'b1;
        for (int i = 0; i < 10 && !ld; i++) begin
            @(posedge ref_clk); #1;
            ld = ctrl_load;
        end
        cs_b = 1'b1;
        h_drv = ws ? 12'h000 : 12'hF00;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
endmodule
`default_nettype wire

//--- dv/word_byte_parallel_data_port_bench.sv
// Self-checking bench for the word/byte parallel data port.
// Assumes the host model drives all pins; the bench drives the core side.
`timescale 1ns/1ps
`default_nettype none
module word_byte_parallel_data_port_bench;
    logic ref_clk, rst_b, word_sel, cs_b, rd_b, wr_b, result_taken, ctrl_load, tk, ld;
    logic [11:0] data_in, data_out, data_oe, result_data, ctrl_word, d, oe;
    logic [1:0] result_chan;
    int n_mismatch = 0;
    int compares = 0;
    wbp_port uut (.ref_clk(ref_clk), .rst_b(rst_b), .word_sel(word_sel), .cs_b(cs_b),
        .rd_b(rd_b), .wr_b(wr_b), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .result_data(result_data), .result_chan(result_chan), .result_taken(result_taken),
        .ctrl_word(ctrl_word), .ctrl_load(ctrl_load));
    wbp_host_model host (.ref_clk(ref_clk), .word_sel(word_sel), .cs_b(cs_b), .rd_b(rd_b),
        .wr_b(wr_b), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .result_taken(result_taken), .ctrl_load(ctrl_load));
    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic compare(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Back-to-back word reads, each must drive all twelve lines then let go
    task automatic t_word_read();
        for (int i = 0; i < 2; i++) begin
            result_data = i ? 12'h3A6 : 12'hA5C;
            result_chan = 2'h2;
            host.bus_read(1'b1, 1'b0, 1'b0, d, oe, tk);
            compare("taken", 12'h001, {11'h000, tk});
            compare("word data", i ? 12'h3A6 : 12'hA5C, d);
            compare("word drive", 12'hFFF, oe);
            compare("released", 12'h000, data_oe);
        end
    endtask
    // Byte reads: low byte, then high byte for every channel id
    task automatic t_byte_read();
        result_data = 12'hB7D;
        result_chan = 2'h0;
        host.bus_read(1'b0, 1'b0, 1'b0, d, oe, tk);
        compare("low byte", 12'h07D, {4'h0, d[7:0]});
        compare("byte drive", 12'h0FF, oe);
        for (int c = 0; c < 4; c++) begin
            result_chan = c[1:0];
            host.bus_read(1'b0, 1'b1, 1'b0, d, oe, tk);
            compare("high byte", {6'h00, c[1:0], 4'hB}, {4'h0, d[7:0]});
            compare("byte drive", 12'h0FF, oe);
        end
    endtask
    // Strobes without chip select are ignored
    task automatic t_unselected();
        host.bus_read(1'b1, 1'b0, 1'b1, d, oe, tk);
        compare("taken", 12'h000, {11'h000, tk});
        compare("drive", 12'h000, oe);
        host.bus_write(1'b1, 1'b0, 1'b1, 12'h777, ld);
        compare("load", 12'h000, {11'h000, ld});
        compare("ctrl", 12'h000, ctrl_word);
    endtask
    // Word write, then a byte pair; the control word changes only on the high byte
    task automatic t_writes();
        host.bus_write(1'b1, 1'b0, 1'b0, 12'h3C7, ld);
        compare("load", 12'h001, {11'h000, ld});
        compare("ctrl", 12'h3C7, ctrl_word);
        host.bus_write(1'b0, 1'b0, 1'b0, 12'h09E, ld);
        compare("load", 12'h000, {11'h000, ld});
        compare("ctrl", 12'h3C7, ctrl_word);
        host.bus_write(1'b0, 1'b1, 1'b0, 12'h005, ld);
        compare("load", 12'h001, {11'h000, ld});
        compare("ctrl", 12'h59E, ctrl_word);
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        result_data = 12'h000;
        result_chan = 2'h0;
        repeat (12) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        compare("drive", 12'h000, data_oe);
        compare("ctrl", 12'h000, ctrl_word);
        t_word_read();
        t_byte_read();
        t_unselected();
        t_writes();
        tally_and_finish();
    end
    // Watchdog well beyond the roughly 180 cycles the tests need
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
